// *** offline_pwm_controller_logic_test.sv ***
`timescale 1ns/1ps
module offline_pwm_controller_logic_test;
    import ofpc_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rstn = 1'b0;
    ofpc_flags_s       ctl = '0;
    ofpc_flags_s       flags;
    ofpc_drive_s       drive;
    logic [ILIM_W-1:0] ilim_code;
    logic              overload = 1'b0;
    logic [11:0]       ramp_len = 12'h064;
    logic              pwm_trip;
    logic              ocp_trip;
    int                fault_cycles = 0;
    int                err_total = 0;
    int                samples_checked = 0;
    int                a;
    int                b;
    int                p1;

    always #2.5 ref_clk = ~ref_clk;
    always_comb begin
        flags = ctl;
        flags.pwm_trip = pwm_trip;
        flags.ocp_trip = ocp_trip;
    end
    // Cycles spent tripped; the decay scenario compares two readings
    always @(posedge ref_clk) begin
        if (drive.overload_fault === 1'b1) fault_cycles <= fault_cycles + 1;
    end

    ofpc_ctrl #(.HIGH_FREQ(1'b1), .SS_CLKS(512), .OVL_CYCLES(4), .RESTART_CLKS(50)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .flags_async(flags), .drive(drive), .ilim_code(ilim_code));
    ofpc_plant plant_u (.ref_clk(ref_clk), .gate_on(drive.gate_on), .overload(overload),
        .ramp_len(ramp_len), .pwm_trip(pwm_trip), .ocp_trip(ocp_trip));

    task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
            err_total++;
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // Waits for gate (0) or fault (1) to reach v, bounded
    task till(input int sel, input logic v, output int n);
        n = 0;
        while ((sel ? drive.overload_fault : drive.gate_on) !== v && n < 12000) begin
            @(negedge ref_clk);
            n++;
        end
        chk("wait", 12'h000, 12'(n >= 12000));
    endtask : till

    task results();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task t_start();
        @(posedge ref_clk) ctl.bulk_start_ok <= 1'b1;
        cyc(20);
        chk("gate lock", 12'h0, 12'(drive.gate_on));
        chk("hv start", 12'h1, 12'(drive.hv_source_en));
        // Supply up, self-biased, feedback input not grounded yet
        @(posedge ref_clk) ctl <= 11'h7d0;
        cyc(300);
        chk("hv on", 12'h0, 12'(drive.hv_source_en));
        chk("ramp", 12'h1, 12'(ilim_code > 8'h10 && ilim_code < 8'hf0));
        cyc(400);
        chk("limit", {4'h0, ILIM_FULL}, 12'(ilim_code));
        till(0, 1'b1, a);
        $display("start done");
    endtask : t_start

    task t_cycle();
        till(0, 1'b0, a);
        chk("pwm width", 12'h1, 12'(a >= 100 && a <= 112));
        till(0, 1'b1, b);
        p1 = a + b;
        chk("period", 12'h1, 12'(p1 >= 1739 - 124 && p1 <= 1739 + 124));
        till(0, 1'b0, a);
        till(0, 1'b1, b);
        chk("dither", 12'h1, 12'(p1 != a + b));
        @(posedge ref_clk) overload <= 1'b1;
        till(0, 1'b0, a);
        chk("ocp width", 12'h1, 12'(a >= 98 && a <= 112));
        @(posedge ref_clk) overload <= 1'b0;
        @(posedge ref_clk) ctl.comp_above_sat <= 1'b1;
        till(0, 1'b1, a);
        till(0, 1'b0, a);
        chk("sat width", 12'h1, 12'(a > 1200 && a < 1400));
        @(posedge ref_clk) ctl.comp_above_sat <= 1'b0;
        $display("cycle done");
    endtask : t_cycle

    task pulses(input int n, input logic ovl);
        @(posedge ref_clk) overload <= ovl;
        repeat (n) begin
            till(0, 1'b1, a);
            till(0, 1'b0, a);
        end
    endtask : pulses

    task t_overload();
        @(posedge ref_clk) overload <= 1'b1;
        till(1, 1'b1, a);
        chk("trip time", 12'h1, 12'(a <= 9000));
        chk("gate trip", 12'h0, 12'(drive.gate_on));
        till(1, 1'b0, b);
        chk("restart", 12'h1, 12'(b >= 46 && b <= 54));
        chk("soft again", 12'h1, 12'(ilim_code < 8'h08));
        till(1, 1'b1, a);
        chk("retrip", 12'h1, 12'(a <= 9000));
        @(posedge ref_clk) overload <= 1'b0;
        till(1, 1'b0, b);
        till(0, 1'b0, a);
        b = fault_cycles;
        pulses(3, 1'b1);
        pulses(3, 1'b0);
        pulses(3, 1'b1);
        pulses(1, 1'b0);
        chk("decay", 12'h0, 12'(fault_cycles - b));
        $display("overload done");
    endtask : t_overload

    task t_burst();
        @(posedge ref_clk) ctl[4:3] <= 2'b00;
        cyc(10);
        chk("burst in", 12'h1, 12'(drive.burst_active));
        chk("burst lim", {4'h0, ILIM_BURST}, 12'(ilim_code));
        cyc(2000);
        chk("burst gate", 12'h0, 12'(drive.gate_on));
        @(posedge ref_clk) ctl.comp_above_burst <= 1'b1;
        cyc(20);
        chk("burst hys", 12'h1, 12'(drive.burst_active));
        @(posedge ref_clk) ctl.comp_above_hys <= 1'b1;
        cyc(10);
        chk("burst out", 12'h0, 12'(drive.burst_active));
        till(0, 1'b1, a);
        $display("burst done");
    endtask : t_burst

    task t_supply();
        chk("ea on", 12'h0, 12'(drive.ea_disable));
        @(posedge ref_clk) ctl.fb_grounded <= 1'b1;
        cyc(12);
        chk("ea off", 12'h1, 12'(drive.ea_disable));
        @(posedge ref_clk) ctl[9:6] <= 4'b0111;
        till(0, 1'b1, a);
        till(0, 1'b0, a);
        cyc(8);
        chk("self charge", 12'h1, 12'(drive.hv_source_en));
        @(posedge ref_clk) ctl.self_bias <= 1'b0;
        cyc(8);
        chk("aux charge", 12'h0, 12'(drive.hv_source_en));
        @(posedge ref_clk) ctl[8:7] <= 2'b00;
        cyc(8);
        chk("down gate", 12'h0, 12'(drive.gate_on));
        cyc(2500);
        chk("down hold", 12'h0, 12'(drive.gate_on));
        $display("supply done");
    endtask : t_supply

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        t_start();
        t_cycle();
        t_overload();
        t_burst();
        t_supply();
        results();
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        results();
    end
endmodule : offline_pwm_controller_logic_test

// *** ofpc_ctrl.sv ***
// Functional notes
// - Gate held low whenever supply is in lockout.
// - Charge source on at bulk start; off when supply reaches turn-on.
// - Self-bias: charge only in off time, supply between cs-on and turn-on.
// - Aux supply: charge source off while supply above cs-on threshold.
// - Switching stops once supply falls below turn-off threshold.
// - Nominal period from fixed rate, 60 kHz or 115 kHz variant.
// - Frequency dithered 4 kHz or 8 kHz deep at 230 Hz rate.
// - Current limit ramps up to default over soft-start duration.
// - Soft-start reruns on every start attempt and after every fault.
// - Gate off when sensed current reaches compensation-derived level.
// - Gate off in parallel when overcurrent compare trips.
// - Limit pin may lower limit; open pin keeps default limit.
// - Grounded feedback input disables error amplifier, uses internal reference.
// - Compensation above saturation lets current reach the active limit.
// - Compensation below burst threshold enters burst, gate held off.
// - Burst exits only above burst threshold plus hysteresis.
// - Burst mode uses the reduced burst current limit.
// - Up-down counter: up on limit cycles, down otherwise.
// - Counter reaching overload time disables gate turn-on.
// - After trip, wait restart time then restart with soft-start.
// - Trip and restart repeat while overload persists.
// - Removed overload: counter decays to zero, saturates, switching continues.
`timescale 1ns/1ps
module ofpc_ctrl #(
    parameter bit          HIGH_FREQ    = 1'b0,
    parameter int unsigned SS_CLKS      = ofpc_pkg::SS_CLKS_DEF,
    parameter int unsigned OVL_CYCLES   = ofpc_pkg::OVL_CYC_LOW,
    parameter int unsigned RESTART_CLKS = ofpc_pkg::RESTART_CLKS_DEF
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rstn,
    // Analog flags
    input  wire ofpc_pkg::ofpc_flags_s    flags_async,
    // Drive and status
    output ofpc_pkg::ofpc_drive_s         drive,
    output logic [ofpc_pkg::ILIM_W-1:0]   ilim_code
);
    import ofpc_pkg::*;

    localparam int unsigned F_HZ   = HIGH_FREQ ? FOSC_HIGH_HZ : FOSC_LOW_HZ;
    localparam int unsigned DEV_HZ = HIGH_FREQ ? FDEV_HIGH_HZ : FDEV_LOW_HZ;
    localparam int unsigned NOM    = CLK_HZ / F_HZ;
    // Period deviation approximates T * df / f
    localparam int unsigned DEV    = NOM * DEV_HZ / F_HZ;
    localparam int unsigned STEP_R = 4 * DEV * FMOD_HZ / F_HZ;
    localparam int unsigned STEP   = (STEP_R == 0) ? 1 : STEP_R;
    localparam int unsigned MAXON  = NOM * MAX_DUTY_PCT / 100;
    localparam int unsigned SS_PRE = SS_CLKS / SS_STEPS;
    localparam int unsigned SS_W   = $clog2(SS_PRE + 1);
    localparam int unsigned OV_W   = $clog2(OVL_CYCLES + 1);
    localparam int unsigned RS_W   = $clog2(RESTART_CLKS + 1);
    localparam int unsigned FW     = $bits(ofpc_flags_s);

    localparam logic signed [PER_W-1:0] DEV_S  = PER_W'(DEV);
    localparam logic signed [PER_W-1:0] STEP_S = PER_W'(STEP);
    localparam logic [PER_W-1:0]        NOM_V  = PER_W'(NOM);
    localparam logic [PER_W-1:0]        MAX_V  = PER_W'(MAXON);
    localparam logic [SS_W-1:0]         SS_END = SS_W'(SS_PRE - 1);
    localparam logic [OV_W-1:0]         OV_END = OV_W'(OVL_CYCLES);
    localparam logic [RS_W-1:0]         RS_END = RS_W'(RESTART_CLKS - 1);

    generate
        if (SS_CLKS < SS_STEPS) begin : g_bad_ss
            $error("SS_CLKS too small for the ramp");
        end
        if (OVL_CYCLES < 1 || RESTART_CLKS < 1) begin : g_bad_cnt
            $error("Overload and restart counts must be nonzero");
        end
        if (NOM + DEV >= (1 << PER_W)) begin : g_bad_per
            $error("Period does not fit the period counter");
        end
    endgenerate

    // three-stage synchroniser, change taken when stages two and three agree
    logic [FW-1:0] sync1;
    logic [FW-1:0] sync2;
    logic [FW-1:0] sync3;
    ofpc_flags_s   flt;
    ofpc_flags_s   next_flt;

    always_comb begin
        next_flt = ofpc_flags_s'((sync2 & sync3) | (flt & (sync2 ^ sync3)));
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            flt   <= '0;
        end else begin
            sync1 <= flags_async;
            sync2 <= sync1;
            sync3 <= sync2;
            flt   <= next_flt;
        end
    end

    // Control state
    ofpc_state_e              state;
    ofpc_state_e              next_state;
    logic [PER_W-1:0]         phase;
    logic [PER_W-1:0]         next_phase;
    logic [PER_W-1:0]         per_len;
    logic [PER_W-1:0]         next_per_len;
    logic signed [PER_W-1:0]  dith;
    logic signed [PER_W-1:0]  next_dith;
    logic                     dith_up;
    logic                     next_dith_up;
    logic                     ocp_seen;
    logic                     next_ocp_seen;
    logic [OV_W-1:0]          ovl_cnt;
    logic [OV_W-1:0]          next_ovl_cnt;
    logic [RS_W-1:0]          rs_cnt;
    logic [RS_W-1:0]          next_rs_cnt;
    logic [SS_W-1:0]          ss_pre;
    logic [SS_W-1:0]          next_ss_pre;
    logic [ILIM_W-1:0]        ilim_lvl;
    logic [ILIM_W-1:0]        next_ilim_lvl;
    logic                     burst;
    logic                     next_burst;
    logic                     fault;
    logic                     next_fault;
    logic                     next_gate;
    logic                     next_hv;
    logic [ILIM_W-1:0]        next_ilim_code;
    logic                     cyc_end;
    logic                     start_ss;
    logic                     pwm_end;

    always_comb begin
        next_state     = state;
        next_phase     = phase + 1'b1;
        next_per_len   = per_len;
        next_dith      = dith;
        next_dith_up   = dith_up;
        next_ocp_seen  = ocp_seen;
        next_ovl_cnt   = ovl_cnt;
        next_rs_cnt    = '0;
        next_ss_pre    = ss_pre;
        next_ilim_lvl  = ilim_lvl;
        next_burst     = 1'b0;
        next_fault     = fault;
        next_gate      = drive.gate_on;
        start_ss       = 1'b0;
        cyc_end        = (phase == per_len - 1'b1);

        // triangular dither, one step per switching cycle
        if (cyc_end) begin
            next_phase   = '0;
            next_per_len = NOM_V + dith;
            if (dith_up) begin
                if (dith >= DEV_S) begin
                    next_dith_up = 1'b0;
                end else begin
                    next_dith = dith + STEP_S;
                end
            end else begin
                if (dith <= -DEV_S) begin
                    next_dith_up = 1'b1;
                end else begin
                    next_dith = dith - STEP_S;
                end
            end
        end

        // above saturation only the limit compare or max duty ends the pulse
        pwm_end = flt.pwm_trip && !flt.comp_above_sat;

        case (state)
            OFPC_LOCK: begin
                next_gate    = 1'b0;
                next_ovl_cnt = '0;
                if (flt.vdd_above_on) begin
                    next_state = OFPC_RUN;
                    start_ss   = 1'b1;
                end
            end
            OFPC_RUN: begin
                // enter burst below threshold; leave above hysteresis
                next_burst = burst ? !flt.comp_above_hys : !flt.comp_above_burst;
                if (drive.gate_on && flt.ocp_trip) begin
                    next_ocp_seen = 1'b1;
                end
                // pulse-width end; overcurrent end; max duty as backstop
                if (pwm_end || flt.ocp_trip || phase >= MAX_V || next_burst) begin
                    next_gate = 1'b0;
                end
                if (cyc_end) begin
                    next_ocp_seen = 1'b0;
                    next_gate     = !next_burst;
                    if (ocp_seen || (drive.gate_on && flt.ocp_trip)) begin
                        next_ovl_cnt = ovl_cnt + 1'b1;
                    end else if (ovl_cnt != '0) begin
                        next_ovl_cnt = ovl_cnt - 1'b1;
                    end
                end
                if (next_ovl_cnt >= OV_END) begin
                    next_state = OFPC_TRIP;
                    next_gate  = 1'b0;
                    next_burst = 1'b0;
                    next_fault = 1'b1;
                end
                if (!flt.vdd_above_off) begin
                    next_state = OFPC_LOCK;
                    next_gate  = 1'b0;
                    next_burst = 1'b0;
                end
            end
            OFPC_TRIP: begin
                next_gate   = 1'b0;
                next_rs_cnt = rs_cnt + 1'b1;
                // restart after wait; repeats while overload stays
                if (rs_cnt == RS_END) begin
                    next_state = OFPC_RUN;
                    start_ss   = 1'b1;
                end
                if (!flt.vdd_above_off) begin
                    next_state = OFPC_LOCK;
                end
            end
            default: begin
                next_state = OFPC_LOCK;
                next_gate  = 1'b0;
            end
        endcase

        // fresh ramp on every start and restart
        if (start_ss) begin
            next_ss_pre   = '0;
            next_ilim_lvl = '0;
            next_ovl_cnt  = '0;
            next_ocp_seen = 1'b0;
            // fault cleared as the restart attempt begins
            next_fault    = 1'b0;
        // limit ramps to full over the soft-start duration
        end else if (ilim_lvl != ILIM_FULL) begin
            if (ss_pre == SS_END) begin
                next_ss_pre   = '0;
                next_ilim_lvl = ilim_lvl + 1'b1;
            end else begin
                next_ss_pre = ss_pre + 1'b1;
            end
        end

        // reduced limit in burst; full code means default or pin-set limit
        next_ilim_code = next_burst ? ILIM_BURST : next_ilim_lvl;

        // Charge source uses the next gate so it never overlaps an on time
        if (next_state == OFPC_LOCK) begin
            // charge from bulk until turn-on threshold
            next_hv = flt.bulk_start_ok && !flt.vdd_above_on;
        end else if (flt.self_bias) begin
            // off time only, between cs-on and turn-on
            next_hv = !next_gate && flt.vdd_above_cs && !flt.vdd_above_on;
        end else begin
            // aux supply keeps the source off above cs-on
            next_hv = !next_gate && !flt.vdd_above_cs;
        end
        // lockout wins over every other gate decision
        if (next_state == OFPC_LOCK) begin
            next_gate = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= OFPC_LOCK;
            phase    <= '0;
            per_len  <= NOM_V;
            dith     <= '0;
            dith_up  <= 1'b1;
            ocp_seen <= 1'b0;
            ovl_cnt  <= '0;
            rs_cnt   <= '0;
            ss_pre   <= '0;
            ilim_lvl <= '0;
            burst    <= 1'b0;
            fault    <= 1'b0;
            drive    <= '0;
            ilim_code <= '0;
        end else begin
            state    <= next_state;
            phase    <= next_phase;
            per_len  <= next_per_len;
            dith     <= next_dith;
            dith_up  <= next_dith_up;
            ocp_seen <= next_ocp_seen;
            ovl_cnt  <= next_ovl_cnt;
            rs_cnt   <= next_rs_cnt;
            ss_pre   <= next_ss_pre;
            ilim_lvl <= next_ilim_lvl;
            burst    <= next_burst;
            fault    <= next_fault;
            drive.gate_on        <= next_gate;
            drive.hv_source_en   <= next_hv;
            // grounded feedback selects the internal reference path
            drive.ea_disable     <= flt.fb_grounded;
            drive.burst_active   <= next_burst;
            drive.overload_fault <= next_fault;
            ilim_code <= next_ilim_code;
        end
    end

endmodule : ofpc_ctrl

// *** ofpc_ctrl_checker.sv ***
`timescale 1ns/1ps
module ofpc_ctrl_checker
    import ofpc_pkg::*;
#(
    parameter int unsigned RESTART_CLKS = 50
) (
    // Clock and reset
    input wire logic                        ref_clk,
    input wire logic                        rstn,
    // Watched ports
    input wire ofpc_pkg::ofpc_flags_s       flags_async,
    input wire ofpc_pkg::ofpc_drive_s       drive,
    input wire logic [ofpc_pkg::ILIM_W-1:0] ilim_code
);
    int unsigned fault_len;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_len <= 0;
        end else begin
            fault_len <= drive.overload_fault ? fault_len + 1 : 0;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_LOCK_GATE: assert property ((!flags_async.vdd_above_off) [*6] |-> !drive.gate_on)
        else $error("gate high in lockout");
    AST_PWM_END: assert property ($rose(flags_async.pwm_trip) && !flags_async.comp_above_sat
        |-> ##[1:6] !drive.gate_on) else $error("gate kept after pwm compare");
    AST_OCP_END: assert property ($rose(flags_async.ocp_trip) |-> ##[1:6] !drive.gate_on)
        else $error("gate kept after overcurrent");
    AST_BURST_OFF: assert property (drive.burst_active && $past(drive.burst_active)
        |-> !drive.gate_on) else $error("gate high in burst");
    AST_BURST_LIM: assert property (drive.burst_active && $past(drive.burst_active)
        |-> ilim_code == ILIM_BURST) else $error("burst limit wrong");
    AST_BURST_HOLD: assert property ((drive.burst_active && !flags_async.comp_above_hys) [*6]
        |=> drive.burst_active) else $error("burst left below hysteresis");
    AST_TRIP_OFF: assert property (drive.overload_fault && $past(drive.overload_fault)
        |-> !drive.gate_on) else $error("gate high while tripped");
    AST_RESTART_TIME: assert property ($fell(drive.overload_fault) && flags_async.vdd_above_off
        |-> fault_len + 2 >= RESTART_CLKS && fault_len <= RESTART_CLKS + 2)
        else $error("restart wait wrong");
    AST_SS_AGAIN: assert property ($fell(drive.overload_fault) |-> ##[0:2] ilim_code < 8'h04)
        else $error("no fresh soft start");
    AST_HV_OFF: assert property (flags_async.vdd_above_on [*6] |-> !drive.hv_source_en)
        else $error("charge source on above turn-on");
    AST_EA_ISO: assert property ((flags_async.fb_grounded && flags_async.vdd_above_on) [*8]
        |-> drive.ea_disable) else $error("error amp kept on");
endmodule : ofpc_ctrl_checker

bind ofpc_ctrl ofpc_ctrl_checker #(.RESTART_CLKS(RESTART_CLKS)) chk_u (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .flags_async(flags_async),
    .drive(drive),
    .ilim_code(ilim_code)
);

// *** ofpc_pkg.sv ***
package ofpc_pkg;

    // Core clock and switching rates
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned FOSC_LOW_HZ   = 60_000;
    localparam int unsigned FOSC_HIGH_HZ  = 115_000;
    localparam int unsigned FDEV_LOW_HZ   = 4_000;
    localparam int unsigned FDEV_HIGH_HZ  = 8_000;
    localparam int unsigned FMOD_HZ       = 230;

    // Protection and start-up times
    localparam int unsigned SS_TIME_US     = 8500;
    localparam int unsigned OVL_TIME_MS    = 50;
    localparam int unsigned RESTART_TIME_S = 1;

    // Derived default counts
    localparam int unsigned SS_CLKS_DEF      = SS_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OVL_CYC_LOW      = OVL_TIME_MS * FOSC_LOW_HZ / 1000;
    localparam int unsigned RESTART_CLKS_DEF = RESTART_TIME_S * CLK_HZ;

    // Soft-start ramp is split into this many limit steps
    localparam int unsigned SS_STEPS = 256;

    // Current limit levels
    localparam int unsigned ILIM_DEF_MA   = 400;
    localparam int unsigned ILIM_BURST_MA = 85;
    localparam int unsigned ILIM_W        = 8;
    localparam logic [ILIM_W-1:0] ILIM_FULL  = 8'hff;
    localparam logic [ILIM_W-1:0] ILIM_BURST =
        ILIM_W'(ILIM_BURST_MA * 255 / ILIM_DEF_MA);

    // Maximum duty cycle, middle of the allowed band
    localparam int unsigned MAX_DUTY_PCT = 75;

    // Width of the switching period counter
    localparam int unsigned PER_W = 12;

    // Comparator and threshold flags, all asynchronous to ref_clk
    typedef struct packed {
        logic bulk_start_ok;
        logic vdd_above_on;
        logic vdd_above_off;
        logic vdd_above_cs;
        logic self_bias;
        logic fb_grounded;
        logic comp_above_burst;
        logic comp_above_hys;
        logic comp_above_sat;
        logic pwm_trip;
        logic ocp_trip;
    } ofpc_flags_s;

    // Drive and status outputs
    typedef struct packed {
        logic gate_on;
        logic hv_source_en;
        logic ea_disable;
        logic burst_active;
        logic overload_fault;
    } ofpc_drive_s;

    typedef enum logic [1:0] {
        OFPC_LOCK = 2'b00,
        OFPC_RUN  = 2'b01,
        OFPC_TRIP = 2'b11
    } ofpc_state_e;

endpackage : ofpc_pkg

// *** ofpc_plant.sv ***
`timescale 1ns/1ps
module ofpc_plant (
    // Switch and clock
    input  wire logic        ref_clk,
    input  wire logic        gate_on,
    // Load setting
    input  wire logic        overload,
    input  wire logic [11:0] ramp_len,
    // Current compares
    output logic             pwm_trip,
    output logic             ocp_trip
);
    logic [11:0] on_time = 12'h000;
    logic        at_peak;

    // Current only ramps while the switch conducts
    assign at_peak = gate_on && (on_time >= ramp_len);
    always_ff @(posedge ref_clk) begin
        on_time <= gate_on ? on_time + 12'h001 : 12'h000;
    end
    always_ff @(posedge ref_clk) begin
        pwm_trip <= at_peak && !overload;
        ocp_trip <= at_peak && overload;
    end
endmodule : ofpc_plant
